// *** adc_source_model.sv ***
/*
 * Stand-in for the analog front end and decimator of level_ctl.
 * Assumes the block's frame strobe; gives one sample pair per frame.
 */
`timescale 1ns/1ns
module adc_source_model (
  // timing and wanted level
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        frame_i,
  input  wire logic [23:0] level_i,
  // decimated samples
  output logic      [23:0] adc_l_o,
  output logic      [23:0] adc_r_o
);
  // new value only at a frame edge, as a real decimator would
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_l_o <= 24'h000000;
      adc_r_o <= 24'h000000;
    end else if (frame_i) begin
      adc_l_o <= level_i;
      adc_r_o <= level_i;
    end
  end
endmodule

// *** level_ctl.sv ***
/*
 * ADC level control with noise gate and limiter, ADC output polarity,
 * oversampling select, passthrough and dual-buffered digital volume.
 * Assumes decimated ADC samples on the system clock and a Wishbone
 * classic master; no interrupts, one clock domain.
 */
`timescale 1ns/1ns
module level_ctl
  import level_ctl_pkg::*;
#(
  parameter int TIME_SCALE = 1
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // adc samples, boost gain, amp enables and external dac data
  input  wire logic [23:0] adc_l_i,
  input  wire logic [23:0] adc_r_i,
  input  wire logic        boost_l_i,
  input  wire logic        boost_r_i,
  input  wire logic        amp_en_l_i,
  input  wire logic        amp_en_r_i,
  input  wire logic [23:0] dac_ext_l_i,
  input  wire logic [23:0] dac_ext_r_i,
  // outputs
  output logic      [5:0]  gain_l_o,
  output logic      [5:0]  gain_r_o,
  output logic             osr128_o,
  output logic             sample_stb_o,
  output logic      [23:0] adc_out_l_o,
  output logic      [23:0] adc_out_r_o,
  output logic      [23:0] dac_in_l_o,
  output logic      [23:0] dac_in_r_o,
  output logic             gate_o
);
  logic [8:0] limits_r, hold_tgt_r, mode_ad_r, gate_r, adc_ctl_r;
  logic [7:0] vol_l_r, vol_r_r, pend_l_r, pend_r_r;
  logic [7:0] cnt_r;
  logic [5:0] gain_r, lim_cap_r;
  logic       lim_prev_r, ack_r;
  logic [31:0] tick_r, hold_r;
  logic       held_r;
  logic [23:0] sl_r, sr_r, sl2_r, sr2_r;
  logic [7:0] idx;
  logic       wr;

  assign idx = adr_i[9:2];
  assign wr  = cyc_i & stb_i & we_i & ~ack_r & sel_i[0];
  assign ack_o = ack_r;

  // two-flop sync of the analog-side sample words
  always_ff @(posedge clk_i) begin
    sl2_r <= adc_l_i;
    sr2_r <= adc_r_i;
    sl_r  <= sl2_r;
    sr_r  <= sr2_r;
  end

  // bus ack: one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end

  // control registers; one set shared by both channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limits_r   <= RST_LIMITS;
      hold_tgt_r <= RST_HOLD_TGT;
      mode_ad_r  <= RST_MODE_AD;
      gate_r     <= RST_GATE;
      adc_ctl_r  <= RST_ADC_CTL;
    end else if (wr) begin
      case (idx)
        IDX_LIMITS:   limits_r   <= {dat_i[8:7], 1'b0, dat_i[5:0]};
        IDX_HOLD_TGT: hold_tgt_r <= {1'b0, dat_i[7:0]};
        IDX_MODE_AD:  mode_ad_r  <= dat_i[8:0];
        IDX_GATE:     gate_r     <= {5'h00, dat_i[3:0]};
        IDX_ADC_CTL:  adc_ctl_r  <= {5'h00, dat_i[3:0]};
        default: ;
      endcase
    end
  end

  // volume: pending store, simultaneous update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vol_l_r  <= RST_VOL;
      vol_r_r  <= RST_VOL;
      pend_l_r <= RST_VOL;
      pend_r_r <= RST_VOL;
    end else if (wr && (idx == IDX_VOL_L || idx == IDX_VOL_R)) begin
      if (idx == IDX_VOL_L) begin
        pend_l_r <= dat_i[7:0];
        if (dat_i[VOL_UPD_BIT]) begin
          vol_l_r <= dat_i[7:0];
          vol_r_r <= pend_r_r;
        end
      end else begin
        pend_r_r <= dat_i[7:0];
        if (dat_i[VOL_UPD_BIT]) begin
          vol_r_r <= dat_i[7:0];
          vol_l_r <= pend_l_r;
        end
      end
    end
  end

  // read mux; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else begin
      case (idx)
        IDX_LIMITS:   dat_o <= {23'h000000, limits_r};
        IDX_HOLD_TGT: dat_o <= {23'h000000, hold_tgt_r};
        IDX_MODE_AD:  dat_o <= {23'h000000, mode_ad_r};
        IDX_GATE:     dat_o <= {23'h000000, gate_r};
        IDX_ADC_CTL:  dat_o <= {23'h000000, adc_ctl_r};
        IDX_VOL_L:    dat_o <= {24'h000000, vol_l_r};   // update bit reads 0
        IDX_VOL_R:    dat_o <= {24'h000000, vol_r_r};
        IDX_GAIN_RD:  dat_o <= {25'h0000000, gate_o, gain_r};
        default:      dat_o <= 32'h00000000;
      endcase
    end
  end

  // sample strobe: master clock = clk/16, fs = master/128
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  logic [10:0] sdiv_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdiv_r       <= 11'h000;
      sample_stb_o <= 1'b0;
    end else begin
      sdiv_r       <= (sdiv_r == 11'(MCLK_DIV*SAMPLE_DIV-1)) ? 11'h000 : sdiv_r + 11'h001;
      sample_stb_o <= (sdiv_r == 11'h000);
    end
  end
  assign osr128_o = adc_ctl_r[OSR_BIT];  // rate unchanged by osr

  // level detection: peak magnitude (worse channel of those enabled)
  logic [1:0]  en;
  logic        lim, nrm, gate_en;
  logic [22:0] mag_l, mag_r, peak;
  logic [22:0] tgt, tgt_lo;
  logic [5:0]  minc, maxc;
  assign en   = limits_r[EN_LSB +: 2];
  assign lim  = mode_ad_r[MODE_BIT] & (en != 2'b00);
  assign nrm  = ~mode_ad_r[MODE_BIT] & (en != 2'b00);
  assign mag_l = sl_r[23] ? 23'(-sl_r) : sl_r[22:0];
  assign mag_r = sr_r[23] ? 23'(-sr_r) : sr_r[22:0];
  always_comb begin
    peak = 23'h000000;
    if (en[1] && mag_l > peak) peak = mag_l;
    if (en[0] && mag_r > peak) peak = mag_r;
  end
  // target: -1.5dB per code below -1.5dBFS, approximated as scaled linear
  assign tgt    = 23'(({19'h00000, hold_tgt_r[TGT_LSB +: 4]} + 23'h1) << 18);
  assign tgt_lo = 23'(tgt - (tgt >> 3));   // 7/8 of target, about 1.2dB below
  assign minc   = 6'(limits_r[MIN_LSB +: 3] * GAIN_6DB);
  assign maxc   = 6'(limits_r[MAX_LSB +: 3] * GAIN_6DB + MAXG_BASE);

  // noise gate: level referred to input below threshold
  logic [22:0] in_lvl, gate_lvl;
  logic [3:0]  boost_sh;
  assign boost_sh = (boost_l_i | boost_r_i) ? 4'h3 : 4'h0;
  assign in_lvl   = 23'((peak >> (gain_r >> 3)) >> boost_sh);
  assign gate_lvl = 23'({20'h00000, gate_r[GATE_TH_LSB +: 3]} + 23'h1) << 6;
  assign gate_en  = gate_r[GATE_EN_BIT];
  assign gate_o   = gate_en & nrm & (in_lvl < gate_lvl);

  // step periods, doubling per code; limiter tables are faster
  logic [31:0] atk_per, dcy_per, hld_per;
  logic [3:0]  hcode;
  assign atk_per = 32'((lim ? LIM_ATK_CYC : ATK_BASE_CYC) / TIME_SCALE) << mode_ad_r[ATK_LSB +: 4];
  assign dcy_per = 32'((lim ? LIM_DCY_CYC : DCY_BASE_CYC) / TIME_SCALE) << mode_ad_r[DCY_LSB +: 4];
  assign hcode   = (hold_tgt_r[HLD_LSB +: 4] > HOLD_SAT) ? HOLD_SAT : hold_tgt_r[HLD_LSB +: 4];
  assign hld_per = (hcode == 4'h0) ? 32'h0 :
                   32'((HOLD_BASE_CYC / TIME_SCALE) << (hcode - 4'h1));

  // limiter entry captures the current gain as its ceiling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_prev_r <= 1'b0;
      lim_cap_r  <= GAIN_RST;
    end else begin
      lim_prev_r <= lim;
      if (lim && !lim_prev_r) begin
        lim_cap_r <= gain_r;
      end
    end
  end

  // hold timer: peak must stay below target for the full hold time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r <= 32'h0;
      held_r <= 1'b0;
    end else if (peak >= tgt) begin
      hold_r <= 32'h0;
      held_r <= 1'b0;
    end else if (hold_r >= hld_per) begin
      held_r <= 1'b1;
    end else begin
      hold_r <= hold_r + 32'h1;
    end
  end

  // gain stepping state machine
  typedef enum logic [1:0] {ST_IDLE, ST_ATTACK, ST_DECAY} step_t;
  step_t st_r;
  logic  clip;
  logic [5:0] ceil;
  assign clip = (en != 2'b00) & (peak > CLIP_LVL);
  assign ceil = lim ? lim_cap_r : maxc;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= ST_IDLE;
      tick_r <= 32'h0;
      gain_r <= GAIN_RST;
    end else if (en == 2'b00) begin
      st_r   <= ST_IDLE;                 // gain frozen while off
      tick_r <= 32'h0;
    end else begin
      tick_r <= tick_r + 32'h1;
      case (st_r)
        ST_IDLE: begin
          tick_r <= 32'h0;
          if (clip || peak > tgt) begin
            st_r <= ST_ATTACK;
          end else if (peak < tgt_lo && held_r && !gate_o) begin
            st_r <= ST_DECAY;
          end
        end
        ST_ATTACK: begin
          // clipping uses the fastest attack regardless of setting
          if (clip ? tick_r >= 32'(LIM_ATK_CYC / TIME_SCALE) : tick_r >= atk_per) begin
            tick_r <= 32'h0;
            if (gain_r > minc) begin
              gain_r <= gain_r - 6'h01;
            end
            if (!clip && peak < tgt_lo) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_DECAY: begin
          if (clip || peak > tgt || gate_o) begin
            st_r <= ST_IDLE;
          end else if (tick_r >= dcy_per) begin
            tick_r <= 32'h0;
            if (gain_r < ceil) begin
              gain_r <= gain_r + 6'h01;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // per-channel gain: a disabled amp or channel keeps its last value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_l_o <= GAIN_RST;
      gain_r_o <= GAIN_RST;
    end else begin
      if (en[1] && amp_en_l_i) gain_l_o <= gain_r;
      if (en[0] && amp_en_r_i) gain_r_o <= gain_r;
    end
  end

  // output path: volume, polarity, passthrough
  function automatic logic [23:0] scale(input logic [23:0] s, input logic [7:0] v, input logic inv);
    logic [23:0] a;
    a = 24'($signed(s) >>> ((8'hFF - v) >> 4));  // coarse 6dB ladder by shifts, one step per 16 codes
    if (v == VOL_MUTE) a = 24'h000000;
    return inv ? 24'(-a) : a;
  endfunction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_out_l_o <= 24'h000000;
      adc_out_r_o <= 24'h000000;
      dac_in_l_o  <= 24'h000000;
      dac_in_r_o  <= 24'h000000;
    end else if (sample_stb_o) begin
      adc_out_l_o <= scale(sl_r, vol_l_r, adc_ctl_r[INV_L_BIT]);
      adc_out_r_o <= scale(sr_r, vol_r_r, adc_ctl_r[INV_R_BIT]);
      // passthrough replaces external dac data; adc output stays live
      dac_in_l_o  <= adc_ctl_r[PASS_BIT] ? scale(sl_r, vol_l_r, adc_ctl_r[INV_L_BIT]) : dac_ext_l_i;
      dac_in_r_o  <= adc_ctl_r[PASS_BIT] ? scale(sr_r, vol_r_r, adc_ctl_r[INV_R_BIT]) : dac_ext_r_i;
    end
  end
endmodule

// *** level_ctl_chk.sv ***
/*
 * Port-level assertions for level_ctl.
 * Assumes the bench's master keeps sel_i at all ones; bound below.
 */
`timescale 1ns/1ns
module level_ctl_chk
  import level_ctl_pkg::*;
(
  // bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // audio path
  input wire logic        amp_en_l_i,
  input wire logic [5:0]  gain_l_o,
  input wire logic [5:0]  gain_r_o,
  input wire logic        osr128_o,
  input wire logic        sample_stb_o,
  input wire logic [23:0] adc_out_l_o,
  input wire logic [23:0] dac_in_l_o,
  input wire logic        gate_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0]  en_r;
  logic        mode_r;
  logic        gate_en_r;
  logic        pass_r;
  logic        seen_r;
  logic [10:0] cnt_r;
  logic [5:0]  cap_r;
  wire         wr  = cyc_i && stb_i && we_i && !ack_o;
  wire         lim = mode_r && (en_r != 2'b00);
  // shadow of control bits, updated on the edge a write is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= 2'b00;
      mode_r <= 1'b0;
      gate_en_r <= 1'b0;
      pass_r <= 1'b0;
    end else if (wr) begin
      if (adr_i == {IDX_LIMITS, 2'b00}) en_r <= dat_i[8:7];
      if (adr_i == {IDX_MODE_AD, 2'b00}) mode_r <= dat_i[MODE_BIT];
      if (adr_i == {IDX_GATE, 2'b00}) gate_en_r <= dat_i[GATE_EN_BIT];
      if (adr_i == {IDX_ADC_CTL, 2'b00}) pass_r <= dat_i[PASS_BIT];
    end
  end
  // cycles since last frame; first frame after reset has no reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 11'h000;
      seen_r <= 1'b0;
    end else if (sample_stb_o) begin
      cnt_r <= 11'h000;
      seen_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 11'h001;
    end
  end
  // gain frozen as ceiling while limiter runs
  always_ff @(posedge clk_i) begin
    if (!lim) cap_r <= gain_r_o;
  end
  sequence bus_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence gated_twice;
    gate_o ##1 gate_o;
  endsequence
  ack_latency_a: assert property (bus_take |=> ack_o) else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  frame_period_a: assert property (sample_stb_o && seen_r |-> cnt_r == 11'h7FF) else $error("frame period");
  out_hold_a: assert property (!sample_stb_o && !$past(sample_stb_o) |-> $stable(adc_out_l_o))
    else $error("output moved off frame");
  osr_follow_a: assert property ($changed(osr128_o) |-> ack_o && $past(we_i)) else $error("osr moved");
  pass_mirror_a: assert property (pass_r && $past(pass_r, 4) && $past(sample_stb_o, 2) |-> dac_in_l_o == adc_out_l_o)
    else $error("passthrough data");
  gate_off_a: assert property (!gate_en_r |-> !gate_o) else $error("gate while off");
  gate_freeze_a: assert property (gated_twice ##0 (en_r == 2'b11 && !lim) |-> gain_r_o <= $past(gain_r_o))
    else $error("gain rose under gate");
  amp_hold_a: assert property (!amp_en_l_i [*3] |-> $stable(gain_l_o)) else $error("idle amp gain moved");
  lim_ceiling_a: assert property (lim && $past(lim) |-> gain_r_o <= cap_r) else $error("limiter raised gain");
endmodule
bind level_ctl level_ctl_chk level_ctl_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o,
  .amp_en_l_i, .gain_l_o, .gain_r_o, .osr128_o, .sample_stb_o, .adc_out_l_o, .dac_in_l_o, .gate_o);

// *** level_ctl_pkg.sv ***
/*
 * Constants for the ADC level-control and digital-volume block: register
 * indices and field layout, reset values, timing counts.
 * Assumes a 100 MHz system clock and a Wishbone classic bus, 32-bit data.
 */
package level_ctl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LIMITS   = 8'h20;
  localparam logic [7:0] IDX_HOLD_TGT = 8'h21;
  localparam logic [7:0] IDX_MODE_AD  = 8'h22;
  localparam logic [7:0] IDX_GATE     = 8'h23;
  localparam logic [7:0] IDX_ADC_CTL  = 8'h24;
  localparam logic [7:0] IDX_VOL_L    = 8'h25;
  localparam logic [7:0] IDX_VOL_R    = 8'h26;
  localparam logic [7:0] IDX_GAIN_RD  = 8'h27;
  // reset values
  localparam logic [8:0] RST_LIMITS   = 9'h038;
  localparam logic [8:0] RST_HOLD_TGT = 9'h00B;
  localparam logic [8:0] RST_MODE_AD  = 9'h032;
  localparam logic [8:0] RST_GATE     = 9'h000;
  localparam logic [8:0] RST_ADC_CTL  = 9'h000;
  localparam logic [7:0] RST_VOL      = 8'hFF;
  // field positions
  localparam int MIN_LSB = 0;
  localparam int MAX_LSB = 3;
  localparam int EN_LSB  = 7;
  localparam int TGT_LSB = 0;
  localparam int HLD_LSB = 4;
  localparam int ATK_LSB = 0;
  localparam int DCY_LSB = 4;
  localparam int MODE_BIT = 8;
  localparam int GATE_EN_BIT = 3;
  localparam int GATE_TH_LSB = 0;
  localparam int OSR_BIT = 0;
  localparam int INV_L_BIT = 1;
  localparam int INV_R_BIT = 2;
  localparam int PASS_BIT = 3;
  localparam int VOL_UPD_BIT = 8;
  localparam logic [3:0] HOLD_SAT = 4'hA;
  localparam logic [7:0] VOL_MUTE = 8'h00;
  // gain in 0.75dB steps, 6-bit code: code 0 = -12dB, 63 = +35.25dB
  localparam logic [5:0] GAIN_RST = 6'h10;
  localparam logic [5:0] GAIN_6DB = 6'h08;
  localparam logic [5:0] MAXG_BASE = 6'h07;
  // timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int MCLK_DIV    = 16;
  localparam int SAMPLE_DIV  = 128;
  localparam int HOLD_BASE_NS   = 2_000_000;
  localparam int ATK_BASE_NS    = 125_000;
  localparam int LIM_ATK_NS     = 31_000;
  localparam int DCY_BASE_NS    = 500_000;
  localparam int LIM_DCY_NS     = 125_000;
  localparam int HOLD_BASE_CYC  = HOLD_BASE_NS / 10;
  localparam int ATK_BASE_CYC   = ATK_BASE_NS / 10;
  localparam int LIM_ATK_CYC    = LIM_ATK_NS / 10;
  localparam int DCY_BASE_CYC   = DCY_BASE_NS / 10;
  localparam int LIM_DCY_CYC    = LIM_DCY_NS / 10;
  // 87.5% of 24-bit full scale
  localparam logic [22:0] CLIP_LVL = 23'h700000;
endpackage

// *** level_ctl_tb.sv ***
/*
 * Self-checking bench for level_ctl with a sample source model.
 * Assumes the checker file is compiled alongside; timing scaled by 100.
 */
`timescale 1ns/1ns
module level_ctl_tb
  import level_ctl_pkg::*;
();
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [9:0]  adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [23:0] adc_l_i, adc_r_i, dac_ext_l_i, dac_ext_r_i, level;
  logic        amp_en_l_i, amp_en_r_i, osr128_o, sample_stb_o, gate_o;
  logic [5:0]  gain_l_o, gain_r_o, g;
  logic [23:0] adc_out_l_o, adc_out_r_o, dac_in_l_o, dac_in_r_o;
  int          err_total, n_compared;
  level_ctl #(.TIME_SCALE(100)) level_ctl_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF),
    .dat_i, .dat_o, .ack_o, .adc_l_i, .adc_r_i, .boost_l_i(1'b0), .boost_r_i(1'b0), .amp_en_l_i, .amp_en_r_i,
    .dac_ext_l_i, .dac_ext_r_i, .gain_l_o, .gain_r_o, .osr128_o, .sample_stb_o, .adc_out_l_o, .adc_out_r_o,
    .dac_in_l_o, .dac_in_r_o, .gate_o);
  adc_source_model adc_source_model_i (.clk_i, .rst_i, .frame_i(sample_stb_o), .level_i(level),
    .adc_l_o(adc_l_i), .adc_r_o(adc_r_i));
  // one classic cycle; held until ack is seen high
  task automatic wb(input logic [9:0] a, input logic [8:0] d, input logic w = 1'b1);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {23'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 16) err_total++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a frame is a fixed 2048 clocks
  task automatic frames(input int n);
    repeat (n * SAMPLE_DIV * MCLK_DIV) @(posedge clk_i);
  endtask
  // reset values, readback, unmapped place
  task automatic t_regs();
    logic [9:0] a [6] = '{10'h080, 10'h084, 10'h088, 10'h08C, 10'h090, 10'h3FC};
    logic [8:0] e [6] = '{RST_LIMITS, RST_HOLD_TGT, RST_MODE_AD, RST_GATE, RST_ADC_CTL, 9'h000};
    for (int i = 0; i < 6; i++) begin
      wb(a[i], 9'h000, 1'b0);
      chk(q, {23'h0, e[i]});
    end
    chk({26'h0, gain_l_o}, {26'h0, GAIN_RST});
    wb(10'h084, 9'h0A7);
    wb(10'h084, 9'h000, 1'b0);
    chk(q, 32'h0A7);
    wb(10'h084, RST_HOLD_TGT);
    wb(10'h3FC, 9'h1FF);
    wb(10'h3FC, 9'h000, 1'b0);
    chk(q, 32'h0);
  endtask
  // polarity, passthrough, oversampling
  task automatic t_path();
    level <= 24'h012345;
    dac_ext_l_i <= 24'h0ABCDE;
    dac_ext_r_i <= 24'h0ABCDE;
    wb(10'h090, 9'h002);
    frames(3);
    chk({8'h00, adc_out_l_o}, 32'hFEDCBB);
    chk({8'h00, adc_out_r_o}, 32'h012345);
    chk({8'h00, dac_in_l_o}, 32'h0ABCDE);
    chk({8'h00, dac_in_r_o}, 32'h0ABCDE);
    wb(10'h090, 9'h009);
    chk({31'h0, osr128_o}, 32'h1);
    frames(3);
    chk({8'h00, dac_in_l_o}, 32'h012345);
    chk({8'h00, dac_in_r_o}, 32'h012345);
    chk({8'h00, adc_out_l_o}, 32'h012345);
  endtask
  // pending volume, then joint update to mute
  task automatic t_vol();
    wb(10'h094, 9'h000);
    frames(3);
    chk({8'h00, adc_out_l_o}, 32'h012345);
    wb(10'h098, 9'h100);
    frames(3);
    chk({8'h00, adc_out_l_o}, 32'h0);
    chk({8'h00, adc_out_r_o}, 32'h0);
    wb(10'h094, 9'h0FF);
    wb(10'h098, 9'h1FF);
    wb(10'h090, 9'h000);
  endtask
  // gate, idle amp, decay, limiter, clip
  task automatic t_alc();
    level <= 24'h000010;
    wb(10'h08C, 9'h00F);
    wb(10'h080, 9'h1B8);
    frames(4);
    chk({31'h0, gate_o}, 32'h1);
    chk({26'h0, gain_r_o}, {26'h0, GAIN_RST});
    // live readback: gate flag above the gain code
    wb(10'h09C, 9'h000, 1'b0);
    chk(q, {25'h0, 1'b1, GAIN_RST});
    wb(10'h08C, 9'h000);
    chk({31'h0, gate_o}, 32'h0);
    amp_en_l_i <= 1'b0;
    frames(6);
    chk({26'h0, gain_l_o}, {26'h0, GAIN_RST});
    chk({31'h0, gain_r_o > GAIN_RST}, 32'h1);
    g = gain_r_o;
    wb(10'h088, 9'h132);
    frames(4);
    chk({31'h0, gain_r_o <= g}, 32'h1);
    level <= 24'h7FFFFF;
    frames(2);
    chk({31'h0, gain_r_o < g}, 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // main sequence after a five-cycle reset
  initial begin
    {rst_i, cyc_i, stb_i, we_i, amp_en_l_i, amp_en_r_i} = 6'b100011;
    {adr_i, dat_i, dac_ext_l_i, dac_ext_r_i, level} = '0;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_path();
    t_vol();
    t_alc();
    tally_and_finish();
  end
  // hang guard well above the expected 60k cycles
  initial begin
    repeat (95000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule
